// [dv/adcc_control_properties.sv]
`include "adcc_defines.svh"
module adcc_control_properties (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       window_match,
   input wire logic       analog_powered,
   input wire logic       track_enable,
   input wire logic       sample_hold,
   input wire logic       conv_done_pulse,
   input wire logic       left_justify,
   input wire logic       burst_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ====
   // Steps
   sequence ctl_wr; sfr_wr && sfr_addr == `ADCC_ADDR_CONTROL; endsequence
   sequence ctl_rd; sfr_addr == `ADCC_ADDR_CONTROL; endsequence
   sequence idle; !track_enable && !sample_hold; endsequence
   // ====
   // Checks
   // Two quiet cycles allow for a copy that lags the register by one
   justify_copy_a: assert property (ctl_wr ##1 !sfr_wr [*2] |-> left_justify == $past(sfr_wdata[2], 2))
      else $error("justify copy wrong");
   burst_copy_a: assert property (ctl_wr ##1 !sfr_wr [*2] |-> burst_mode == $past(sfr_wdata[6], 2))
      else $error("burst copy wrong");
   done_pulse_a: assert property (conv_done_pulse |=> !conv_done_pulse)
      else $error("done pulse too long");
   done_read_a: assert property ((conv_done_pulse && !sfr_wr) ##1 ctl_rd
      |=> sfr_rdata[5] && !sfr_rdata[4])
      else $error("done or busy bit wrong");
   window_flag_a: assert property (window_match ##1 ctl_rd |=> sfr_rdata[3])
      else $error("window flag not set");
   busy_start_a: assert property (ctl_wr ##0 (sfr_wdata[7] && sfr_wdata[4]) ##0 idle
      ##1 ctl_rd |=> sfr_rdata[4])
      else $error("busy not set by start");
   start_refused_a: assert property (ctl_wr ##0 (sfr_wdata[7:6] == 2'h0 && sfr_wdata[4]
      && !analog_powered && !burst_mode) ##0 idle |=> idle [*3])
      else $error("start taken while disabled");
   powered_a: assert property (sample_hold |-> analog_powered)
      else $error("converting unpowered");
   track_hold_a: assert property (!(track_enable && sample_hold))
      else $error("track and hold together");
endmodule
bind adcc_control adcc_control_properties chk (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
   .window_match, .analog_powered, .track_enable, .sample_hold, .conv_done_pulse, .left_justify, .burst_mode);

// [dv/tb_adc_conversion_control.sv]
`include "adcc_defines.svh"
module tb_adc_conversion_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       sfr_wr = 1'b0;
   logic       sar_clk_tick = 1'b0;
   logic       convst_pin = 1'b0;
   logic       window_match = 1'b0;
   logic       timer_a_start = 1'b0;
   logic       timer_b_start = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic       analog_powered, track_enable, sample_hold, conv_done_pulse, left_justify, burst_mode;
   int         num_errors = 0;
   int         n_compared = 0;
   int         cyc = 0;
   localparam  logic [7:0] CT = `ADCC_ADDR_CONTROL;
   localparam  logic [7:0] TK = `ADCC_ADDR_TRACKING;
   adcc_control #(.PWR_UNIT(1)) uut (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .sar_clk_tick,
      .timer_a_start, .timer_b_start, .convst_pin, .window_match, .analog_powered, .track_enable,
      .sample_hold, .conv_done_pulse, .left_justify, .burst_mode);
   initial forever #10 clk = ~clk;
   // ====
   // SAR tick every fourth clock, run limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sar_clk_tick <= #1 (cyc % 4 == 3);
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   // ====
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk) #1;
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      @(posedge clk) #1;
      chk(sfr_rdata, exp);
   endtask
   task automatic wait_done();
      for (int i = 0; i < 400 && conv_done_pulse !== 1'b1; i++)
         @(posedge clk) #1;
      chk({7'h00, conv_done_pulse}, 8'h01);
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ====
   // Scenarios
   task automatic t_reset();
      rd(CT, 8'h00);
      rd(TK, 8'hFF);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      wr(CT, 8'h10);
      repeat (4) @(posedge clk) #1;
      rd(CT, 8'h00);
      chk({6'h00, analog_powered, track_enable}, 8'h00);
   endtask
   task automatic t_soft();
      wr(CT, 8'h90);
      rd(CT, 8'h90);
      wait_done();
      rd(CT, 8'hA0);
      wr(CT, 8'h80);
      repeat (3) @(posedge clk) #1;
      rd(CT, 8'h80);
      chk({5'h00, analog_powered, track_enable, sample_hold}, 8'h06);
   endtask
   task automatic t_fields();
      wr(CT, 8'hC4);
      rd(CT, 8'hC4);
      @(posedge clk) #1;
      chk({6'h00, burst_mode, left_justify}, 8'h03);
      wr(CT, 8'h80);
      repeat (2) @(posedge clk) #1;
      chk({6'h00, burst_mode, left_justify}, 8'h00);
   endtask
   task automatic t_window();
      window_match = 1'b1;
      @(posedge clk) #1;
      window_match = 1'b0;
      repeat (5) @(posedge clk) #1;
      rd(CT, 8'h88);
      wr(CT, 8'h80);
      rd(CT, 8'h80);
   endtask
   task automatic t_pin_burst();
      wr(CT, 8'h82);
      convst_pin = 1'b1;
      repeat (4) @(posedge clk) #1;
      convst_pin = 1'b0;
      wait_done();
      rd(CT, 8'hA2);
      wr(TK, 8'h15);
      rd(TK, 8'h15);
      // Burst without enable must wake, convert, then drop power again
      wr(CT, 8'h50);
      wait_done();
      repeat (4) @(posedge clk) #1;
      chk({7'h00, analog_powered}, 8'h00);
   endtask
   task automatic t_timer();
      // Pre-tracking keeps the input tracked while idle
      wr(TK, 8'h08);
      wr(CT, 8'h81);
      timer_b_start = 1'b1;
      @(posedge clk) #1;
      timer_b_start = 1'b0;
      rd(CT, 8'h81);
      chk({7'h00, track_enable}, 8'h01);
      timer_a_start = 1'b1;
      @(posedge clk) #1;
      timer_a_start = 1'b0;
      wait_done();
      rd(CT, 8'hA1);
      wr(CT, 8'h83);
      timer_b_start = 1'b1;
      @(posedge clk) #1;
      timer_b_start = 1'b0;
      wait_done();
      rd(CT, 8'hA3);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk) #1;
      t_reset();
      t_soft();
      t_fields();
      t_window();
      t_pin_burst();
      t_timer();
      end_of_test();
   end
endmodule

// [logic/adcc_control.sv]
`include "adcc_defines.svh"
module adcc_control
   import adcc_pkg::*;
#(
   parameter int PWR_UNIT = 8
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       sar_clk_tick,
   input  wire logic       timer_a_start,
   input  wire logic       timer_b_start,
   input  wire logic       convst_pin,
   input  wire logic       window_match,
   output logic            analog_powered,
   output logic            track_enable,
   output logic            sample_hold,
   output logic            conv_done_pulse,
   output logic            left_justify,
   output logic            burst_mode
);
   typedef enum logic [2:0] {ADCC_IDLE, ADCC_POWERUP, ADCC_TRACK, ADCC_POST, ADCC_CONVERT} adcc_state_e;
   logic [1:0]  rst_sync_ff;
   logic        rst_int_n;
   logic [1:0]  pin_sync_ff;
   logic        pin_prev_ff;
   logic [7:0]  ctrl_ff;
   logic [7:0]  trk_ff;
   adcc_state_e state_ff;
   logic [11:0] cnt_ff;
   logic [3:0]  sys_cnt_ff;
   logic        start_req;
   logic        conv_end;
   logic        wr_ctrl;
   logic        wr_trk;
   logic [4:0]  post_sar;
   logic        need_powerup;
   logic [7:0]  eff_ctrl;
   logic        run_ok;

   // ==========================================
   // Reset and pin synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_ff[1];

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         pin_sync_ff <= 2'h0;
         pin_prev_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[0], convst_pin};
         pin_prev_ff <= pin_sync_ff[1];
      end
   end

   // ==========================================
   // Start selection
   assign wr_ctrl = sfr_wr && (sfr_addr == `ADCC_ADDR_CONTROL);
   assign wr_trk  = sfr_wr && (sfr_addr == `ADCC_ADDR_TRACKING);

   // A control write counts at once, so enable, source and start may share one write
   assign eff_ctrl = wr_ctrl ? sfr_wdata : ctrl_ff;
   assign run_ok   = eff_ctrl[`ADCC_BIT_ENABLE] || eff_ctrl[`ADCC_BIT_BURST];

   always_comb begin
      case (adcc_src_e'(eff_ctrl[`ADCC_SRC_LSB +: 2]))
         ADCC_SRC_SOFTWARE: start_req = wr_ctrl && sfr_wdata[`ADCC_BIT_BUSY];
         ADCC_SRC_PIN:      start_req = pin_sync_ff[1] && !pin_prev_ff;
         ADCC_SRC_TIMER_A:  start_req = timer_a_start;
         ADCC_SRC_TIMER_B:  start_req = timer_b_start;
         default:           start_req = 1'b0;
      endcase
   end

   // Burst without enable powers down between conversions
   assign need_powerup = !eff_ctrl[`ADCC_BIT_ENABLE];

   always_comb begin
      case (trk_ff[`ADCC_TK_LSB +: 2])
         2'h0:    post_sar = 5'h01;
         2'h1:    post_sar = 5'h02;
         2'h2:    post_sar = 5'h04;
         default: post_sar = 5'h08;
      endcase
   end

   // ==========================================
   // Conversion sequencer
   assign conv_end = (state_ff == ADCC_CONVERT) && sar_clk_tick && (cnt_ff == 12'(`ADCC_CONV_SAR_CLKS - 5'h01));

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         state_ff   <= ADCC_IDLE;
         cnt_ff     <= 12'h000;
         sys_cnt_ff <= 4'h0;
      end else begin
         case (state_ff)
            ADCC_IDLE: begin
               cnt_ff     <= 12'h000;
               sys_cnt_ff <= 4'h0;
               // Normal mode ignores starts while disabled
               if (start_req && run_ok) begin
                  if (eff_ctrl[`ADCC_BIT_BURST] && need_powerup) begin
                     state_ff <= ADCC_POWERUP;
                  end else if (adcc_tm_e'(trk_ff[`ADCC_TM_LSB +: 2]) == ADCC_TM_POST) begin
                     state_ff <= ADCC_POST;
                  end else begin
                     state_ff <= ADCC_TRACK;
                  end
               end
            end
            ADCC_POWERUP: begin
               // Power-up time: (field + 1) * PWR_UNIT system clocks
               if (cnt_ff >= 12'((trk_ff[`ADCC_PWR_LSB +: 4] + 1) * PWR_UNIT - 1)) begin
                  cnt_ff   <= 12'h000;
                  state_ff <= (adcc_tm_e'(trk_ff[`ADCC_TM_LSB +: 2]) == ADCC_TM_POST) ? ADCC_POST : ADCC_TRACK;
               end else begin
                  cnt_ff <= cnt_ff + 12'h001;
               end
            end
            ADCC_TRACK: begin
               // Pre-track already done; dual adds post-track
               if (adcc_tm_e'(trk_ff[`ADCC_TM_LSB +: 2]) == ADCC_TM_DUAL) begin
                  state_ff <= ADCC_POST;
               end else begin
                  state_ff <= ADCC_CONVERT;
               end
               cnt_ff <= 12'h000;
            end
            ADCC_POST: begin
               if (sys_cnt_ff < `ADCC_POST_SYS_CLKS) begin
                  sys_cnt_ff <= sys_cnt_ff + 4'h1;
               end else if (sar_clk_tick) begin
                  if (cnt_ff == 12'(post_sar - 5'h01)) begin
                     cnt_ff   <= 12'h000;
                     state_ff <= ADCC_CONVERT;
                  end else begin
                     cnt_ff <= cnt_ff + 12'h001;
                  end
               end
            end
            ADCC_CONVERT: begin
               if (conv_end) begin
                  cnt_ff   <= 12'h000;
                  state_ff <= ADCC_IDLE;
               end else if (sar_clk_tick) begin
                  cnt_ff <= cnt_ff + 12'h001;
               end
            end
            default: state_ff <= ADCC_IDLE;
         endcase
      end
   end

   // ==========================================
   // Control register; hardware sets win over software clears
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ctrl_ff <= `ADCC_RST_CONTROL;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff[`ADCC_BIT_ENABLE] <= sfr_wdata[`ADCC_BIT_ENABLE];
            ctrl_ff[`ADCC_BIT_BURST]  <= sfr_wdata[`ADCC_BIT_BURST];
            ctrl_ff[`ADCC_BIT_LJUST]  <= sfr_wdata[`ADCC_BIT_LJUST];
            ctrl_ff[1:0]              <= sfr_wdata[1:0];
            ctrl_ff[`ADCC_BIT_DONE]   <= sfr_wdata[`ADCC_BIT_DONE];
            ctrl_ff[`ADCC_BIT_WINDOW] <= sfr_wdata[`ADCC_BIT_WINDOW];
         end
         if (conv_end) begin
            ctrl_ff[`ADCC_BIT_DONE] <= 1'b1;
         end
         if (window_match) begin
            ctrl_ff[`ADCC_BIT_WINDOW] <= 1'b1;
         end
         ctrl_ff[`ADCC_BIT_BUSY] <= (state_ff != ADCC_IDLE && !conv_end)
                                    || (state_ff == ADCC_IDLE && start_req && run_ok);
      end
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         trk_ff <= `ADCC_RST_TRACKING;
      end else if (wr_trk) begin
         trk_ff <= sfr_wdata;
      end
   end

   // ==========================================
   // Outputs, all registered
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sfr_rdata       <= 8'h00;
         analog_powered  <= 1'b0;
         track_enable    <= 1'b0;
         sample_hold     <= 1'b0;
         conv_done_pulse <= 1'b0;
         left_justify    <= 1'b0;
         burst_mode      <= 1'b0;
      end else begin
         case (sfr_addr)
            `ADCC_ADDR_CONTROL:  sfr_rdata <= ctrl_ff;
            `ADCC_ADDR_TRACKING: sfr_rdata <= trk_ff;
            default:             sfr_rdata <= 8'h00;
         endcase
         analog_powered  <= ctrl_ff[`ADCC_BIT_ENABLE] || (state_ff != ADCC_IDLE);
         track_enable    <= (state_ff == ADCC_TRACK) || (state_ff == ADCC_POST)
                            || (state_ff == ADCC_IDLE && ctrl_ff[`ADCC_BIT_ENABLE]
                                && adcc_tm_e'(trk_ff[`ADCC_TM_LSB +: 2]) != ADCC_TM_POST);
         sample_hold     <= (state_ff == ADCC_CONVERT);
         conv_done_pulse <= conv_end;
         left_justify    <= ctrl_ff[`ADCC_BIT_LJUST];
         burst_mode      <= ctrl_ff[`ADCC_BIT_BURST];
      end
   end
endmodule

// [logic/adcc_defines.svh]
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
// ==========================================
// Register addresses
`define ADCC_ADDR_CONTROL   8'hE8
`define ADCC_ADDR_TRACKING  8'hBA
// ==========================================
// Control register fields
`define ADCC_BIT_ENABLE     3'h7
`define ADCC_BIT_BURST      3'h6
`define ADCC_BIT_DONE       3'h5
`define ADCC_BIT_BUSY       3'h4
`define ADCC_BIT_WINDOW     3'h3
`define ADCC_BIT_LJUST      3'h2
`define ADCC_SRC_LSB        0
`define ADCC_RST_CONTROL    8'h00
// ==========================================
// Tracking register fields
`define ADCC_PWR_LSB        4
`define ADCC_TM_LSB         2
`define ADCC_TK_LSB         0
`define ADCC_RST_TRACKING   8'hFF
// ==========================================
// Timing
`define ADCC_CONV_SAR_CLKS  5'h0D
`define ADCC_POST_SYS_CLKS  4'h2
`endif

// [logic/adcc_pkg.sv]
package adcc_pkg;
   typedef enum logic [1:0] {
      ADCC_SRC_SOFTWARE = 2'h0,
      ADCC_SRC_TIMER_A  = 2'h1,
      ADCC_SRC_PIN      = 2'h2,
      ADCC_SRC_TIMER_B  = 2'h3
   } adcc_src_e;
   typedef enum logic [1:0] {
      ADCC_TM_RESERVED = 2'h0,
      ADCC_TM_POST     = 2'h1,
      ADCC_TM_PRE      = 2'h2,
      ADCC_TM_DUAL     = 2'h3
   } adcc_tm_e;
endpackage
